// file: design/asce_pkg.sv
// Constants shared by the serial character engine
package asce_pkg;
   // Baud tick: receive samples at 16 ticks per bit
   localparam int unsigned OVERSAMPLE = 16;
   localparam logic [3:0] TICK_LAST = 4'hF;
   localparam logic [3:0] TICK_START_MID = 4'h7;
   localparam logic [3:0] TICK_DATA_MID = 4'h9;
   localparam logic [3:0] TICK_VOTE_A = 4'h7;
   localparam logic [3:0] TICK_VOTE_B = 4'h8;
   // Character lengths in data bits
   localparam logic [3:0] BITS_SHORT = 4'h8;
   localparam logic [3:0] BITS_LONG = 4'h9;
   localparam logic [7:0] DIV_RESET = 8'h01;
   localparam logic [8:0] DATA_RESET = 9'h000;
   typedef enum logic [2:0] {
      TX_IDLE = 3'b000,
      TX_PRE = 3'b001,
      TX_START = 3'b010,
      TX_DATA = 3'b011,
      TX_STOP = 3'b100,
      TX_BREAK = 3'b101,
      TX_MARK = 3'b110
   } asce_tx_state_t;
   typedef enum logic [1:0] {
      RX_HUNT = 2'b00,
      RX_START = 2'b01,
      RX_DATA = 2'b10,
      RX_STOP = 2'b11
   } asce_rx_state_t;
endpackage

// file: design/asce_vote.sv
// Three-sample majority vote with noise detection
`timescale 1ns/10ps
module asce_vote (
   input wire logic [2:0] samples, // Three line samples
   output logic level, // Majority value
   output logic noisy // Samples disagree
);
   assign level = (samples[0] & samples[1]) | (samples[0] & samples[2]) | (samples[1] & samples[2]);
   assign noisy = ~((samples == 3'h0) | (samples == 3'h7));
endmodule // asce_vote

// file: design/asce_char_engine.sv
// Full-duplex asynchronous serial character engine
`timescale 1ns/10ps
module asce_char_engine (
   input wire logic clock, // 25 MHz system clock
   input wire logic reset, // Synchronous, active high
   input wire logic [7:0] baudDivisor, // System clocks per tick, zero as one
   input wire logic serialUnitEnable, // Unit enable
   input wire logic txEnable, // Transmitter enable
   input wire logic rxEnable, // Receiver enable
   input wire logic charLengthSelect, // 1 selects nine bits
   input wire logic txNinthBit, // Ninth transmitted bit
   input wire logic sendBrk, // Send break characters
   input wire logic txInvert, // Invert transmit output
   input wire logic txEmptyIrqEnable, // Buffer empty interrupt enable
   input wire logic txDoneIrqEnable, // Done interrupt enable
   input wire logic rxFullIrqEnable, // Receive full interrupt enable
   input wire logic dataWrite, // Write pulse to data location
   input wire logic [7:0] dataWriteValue, // Byte written
   input wire logic dataRead, // Read pulse of data location
   input wire logic statusRead, // Read pulse of first status register
   input wire logic rxLine, // Receive pin level
   output logic txLine, // Transmit pin level
   output logic txLineOe, // Transmit pin driven
   output logic rxLineOwned, // Receive pin claimed
   output logic [7:0] serialDataBuffer, // Received byte
   output logic rxNinthBit, // Received ninth bit
   output logic txBufferEmptyFlag, // Buffer can accept data
   output logic txDoneFlag, // Transmitter fully idle
   output logic rxFullFlag, // Received byte ready
   output logic framingErrFlag, // Stop bit missing
   output logic brkSeenFlag, // Break received
   output logic noiseFlag, // Sample disagreement seen
   output logic overrunFlag, // Byte lost to full buffer
   output logic rxActiveFlag, // Reception in progress
   output logic txIrq, // Transmitter interrupt request
   output logic rxIrq // Receiver interrupt request
);
   // ------------------------------------------------------------
   // Baud tick
   // ------------------------------------------------------------
   logic [7:0] divCount_q;
   logic tick_q;
   always_ff @(posedge clock) begin
      if (reset || !serialUnitEnable) begin
         divCount_q <= asce_pkg::DIV_RESET;
         tick_q <= 1'b0;
      end else if (divCount_q >= baudDivisor) begin
         divCount_q <= asce_pkg::DIV_RESET;
         tick_q <= 1'b1;
      end else begin
         divCount_q <= divCount_q + 8'h01;
         tick_q <= 1'b0;
      end
   end
   // ------------------------------------------------------------
   // Transmitter
   // ------------------------------------------------------------
   // shared tick, independent engines
   asce_pkg::asce_tx_state_t txState_q;
   logic [3:0] txTick_q;
   logic [3:0] txBit_q;
   logic [8:0] txShift_q;
   logic [8:0] txBuf_q;
   logic txBufFull_q;
   logic txEnPrev_q;
   logic idleQueued_q;
   logic txOut;
   logic bitEnd;
   logic [3:0] charBits;
   logic txLoad;
   assign charBits = charLengthSelect ? asce_pkg::BITS_LONG : asce_pkg::BITS_SHORT;
   assign bitEnd = tick_q && (txTick_q == asce_pkg::TICK_LAST);
   // Buffer only moves when the next frame begins from stop, preamble end or mark
   assign txLoad = bitEnd && txBufFull_q && txEnable && !sendBrk && !idleQueued_q
      && ((txState_q == asce_pkg::TX_STOP) || (txState_q == asce_pkg::TX_PRE && txBit_q == 4'h1)
      || (txState_q == asce_pkg::TX_MARK));
   always_ff @(posedge clock) begin
      if (reset || !serialUnitEnable) begin
         txState_q <= asce_pkg::TX_IDLE;
         txTick_q <= 4'h0;
         txBit_q <= 4'h0;
         txShift_q <= asce_pkg::DATA_RESET;
      end else begin
         if (tick_q) begin
            txTick_q <= txTick_q + 4'h1;
         end
         // Shifter takes the buffer at load time, so a write during the start bit is safe
         if (txLoad) begin
            txShift_q <= txBuf_q;
         end
         case (txState_q)
            asce_pkg::TX_IDLE: begin
               if (txEnable && (txBufFull_q || sendBrk)) begin
                  txState_q <= asce_pkg::TX_PRE;
                  txBit_q <= charBits + 4'h2;
                  txTick_q <= 4'h0;
               end
            end
            asce_pkg::TX_PRE, asce_pkg::TX_MARK: begin
               if (bitEnd) begin
                  txBit_q <= txBit_q - 4'h1;
                  if (txBit_q == 4'h1 || txState_q == asce_pkg::TX_MARK) begin
                     if (sendBrk && txEnable) begin
                        txState_q <= asce_pkg::TX_BREAK;
                        txBit_q <= charBits + 4'h2;
                     end else if (txLoad) begin
                        txState_q <= asce_pkg::TX_START;
                     end else begin
                        // Preamble or mark spent and nothing loaded: idle, so done can set
                        txState_q <= asce_pkg::TX_IDLE;
                     end
                  end
               end
            end
            asce_pkg::TX_START: begin
               if (bitEnd) begin
                  txState_q <= asce_pkg::TX_DATA;
                  txBit_q <= charBits;
               end
            end
            asce_pkg::TX_DATA: begin
               if (bitEnd) begin
                  txShift_q <= {1'b0, txShift_q[8:1]};
                  txBit_q <= txBit_q - 4'h1;
                  if (txBit_q == 4'h1) begin
                     txState_q <= asce_pkg::TX_STOP;
                  end
               end
            end
            asce_pkg::TX_STOP: begin
               if (bitEnd) begin
                  if (idleQueued_q && txEnable) begin
                     txState_q <= asce_pkg::TX_PRE;
                     txBit_q <= charBits + 4'h2;
                  end else if (sendBrk && txEnable) begin
                     txState_q <= asce_pkg::TX_BREAK;
                     txBit_q <= charBits + 4'h2;
                  end else if (txLoad) begin
                     txState_q <= asce_pkg::TX_START;
                  end else begin
                     txState_q <= asce_pkg::TX_IDLE;
                  end
               end
            end
            asce_pkg::TX_BREAK: begin
               if (bitEnd) begin
                  txBit_q <= txBit_q - 4'h1;
                  if (txBit_q == 4'h1) begin
                     if (sendBrk && txEnable) begin
                        txBit_q <= charBits + 4'h2;
                     end else begin
                        txState_q <= asce_pkg::TX_MARK;
                     end
                  end
               end
            end
            default: begin
               txState_q <= asce_pkg::TX_IDLE;
            end
         endcase
      end
   end
   always_ff @(posedge clock) begin
      if (reset) begin
         txEnPrev_q <= 1'b0;
         idleQueued_q <= 1'b0;
      end else begin
         txEnPrev_q <= txEnable;
         if (txState_q == asce_pkg::TX_IDLE || (txState_q == asce_pkg::TX_STOP && bitEnd)) begin
            idleQueued_q <= 1'b0;
         end else if (txEnable && !txEnPrev_q && txState_q != asce_pkg::TX_PRE) begin
            idleQueued_q <= 1'b1;
         end
      end
   end
   always_ff @(posedge clock) begin
      if (reset || !serialUnitEnable) begin
         txBuf_q <= asce_pkg::DATA_RESET;
         txBufFull_q <= 1'b0;
      end else if (dataWrite) begin
         txBuf_q <= charLengthSelect ? {txNinthBit, dataWriteValue} : {1'b0, dataWriteValue};
         txBufFull_q <= 1'b1;
      end else if (txLoad) begin
         txBufFull_q <= 1'b0;
      end else if (txState_q == asce_pkg::TX_STOP && bitEnd && idleQueued_q && !txEnPrev_q) begin
         txBufFull_q <= 1'b0;
      end
   end
   always_comb begin
      case (txState_q)
         asce_pkg::TX_START: txOut = 1'b0;
         asce_pkg::TX_DATA: txOut = txShift_q[0];
         asce_pkg::TX_BREAK: txOut = 1'b0;
         default: txOut = 1'b1;
      endcase
   end
   always_ff @(posedge clock) begin
      if (reset) begin
         txLine <= 1'b1;
         txLineOe <= 1'b0;
         rxLineOwned <= 1'b0;
      end else begin
         txLine <= txOut ^ txInvert;
         // Keep driving until the character in progress has ended
         txLineOe <= serialUnitEnable && (txEnable || txState_q != asce_pkg::TX_IDLE);
         rxLineOwned <= serialUnitEnable && rxEnable;
      end
   end
   always_ff @(posedge clock) begin
      if (reset) begin
         txBufferEmptyFlag <= 1'b1;
         txDoneFlag <= 1'b1;
         txIrq <= 1'b0;
      end else begin
         txBufferEmptyFlag <= !txBufFull_q || txLoad;
         txDoneFlag <= !txBufFull_q && txState_q == asce_pkg::TX_IDLE;
         txIrq <= (txEmptyIrqEnable && txBufferEmptyFlag) || (txDoneIrqEnable && txDoneFlag);
      end
   end
   // ------------------------------------------------------------
   // Receiver
   // ------------------------------------------------------------
   asce_pkg::asce_rx_state_t rxState_q;
   logic [3:0] rxTick_q;
   logic [3:0] rxBit_q;
   logic [8:0] rxShift_q;
   logic [2:0] rxSamp_q;
   logic rxPrev_q;
   logic frameNoise_q;
   logic voteLevel;
   logic voteNoisy;
   logic rxDone;
   logic isBreak;
   asce_vote u_vote (
      .samples(rxSamp_q),
      .level(voteLevel),
      .noisy(voteNoisy)
   );
   assign rxDone = tick_q && rxState_q == asce_pkg::RX_STOP && rxTick_q == asce_pkg::TICK_DATA_MID;
   assign isBreak = (rxShift_q == asce_pkg::DATA_RESET) && !voteLevel;
   always_ff @(posedge clock) begin
      if (reset || !serialUnitEnable || !rxEnable) begin
         rxState_q <= asce_pkg::RX_HUNT;
         rxTick_q <= 4'h0;
         rxBit_q <= 4'h0;
         rxShift_q <= asce_pkg::DATA_RESET;
         rxSamp_q <= 3'h7;
         rxPrev_q <= 1'b1;
         frameNoise_q <= 1'b0;
      end else if (tick_q) begin
         rxTick_q <= rxTick_q + 4'h1;
         rxSamp_q <= {rxSamp_q[1:0], rxLine};
         case (rxState_q)
            asce_pkg::RX_HUNT: begin
               // Start edge resyncs the tick count
               // Three idle ones first, so a zero stop bit cannot retrigger
               if (!rxLine && rxSamp_q == 3'h7) begin
                  rxState_q <= asce_pkg::RX_START;
                  rxTick_q <= 4'h1;
                  frameNoise_q <= 1'b0;
               end
            end
            asce_pkg::RX_START: begin
               if (rxTick_q == asce_pkg::TICK_START_MID) begin
                  if (voteLevel) begin
                     rxState_q <= asce_pkg::RX_HUNT;
                  end else begin
                     frameNoise_q <= voteNoisy;
                  end
               end else if (rxTick_q == asce_pkg::TICK_LAST) begin
                  rxState_q <= asce_pkg::RX_DATA;
                  rxBit_q <= charBits;
                  rxPrev_q <= 1'b0;
               end
            end
            asce_pkg::RX_DATA: begin
               if (rxTick_q == asce_pkg::TICK_DATA_MID) begin
                  rxShift_q <= charLengthSelect ? {voteLevel, rxShift_q[8:1]} : {1'b0, voteLevel, rxShift_q[7:1]};
                  rxPrev_q <= voteLevel;
                  frameNoise_q <= frameNoise_q | voteNoisy;
                  // resync on valid one-to-zero data edge
                  if (rxPrev_q && !voteLevel) begin
                     rxTick_q <= asce_pkg::TICK_DATA_MID + 4'h1;
                  end
                  rxBit_q <= rxBit_q - 4'h1;
               end else if (rxTick_q == asce_pkg::TICK_LAST && rxBit_q == 4'h0) begin
                  rxState_q <= asce_pkg::RX_STOP;
               end
            end
            asce_pkg::RX_STOP: begin
               if (rxTick_q == asce_pkg::TICK_DATA_MID) begin
                  rxState_q <= asce_pkg::RX_HUNT;
               end
            end
            default: begin
               rxState_q <= asce_pkg::RX_HUNT;
            end
         endcase
      end
   end
   always_ff @(posedge clock) begin
      if (reset) begin
         serialDataBuffer <= 8'h00;
         rxNinthBit <= 1'b0;
         rxFullFlag <= 1'b0;
         framingErrFlag <= 1'b0;
         brkSeenFlag <= 1'b0;
         noiseFlag <= 1'b0;
         overrunFlag <= 1'b0;
      end else if (rxDone) begin
         // Set wins over a same-cycle clearing read
         serialDataBuffer <= isBreak ? 8'h00 : rxShift_q[7:0];
         // ninth bit or bit 7 copy
         rxNinthBit <= isBreak ? 1'b0 : (charLengthSelect ? rxShift_q[8] : rxShift_q[7]);
         rxFullFlag <= 1'b1;
         framingErrFlag <= !voteLevel;
         brkSeenFlag <= isBreak;
         noiseFlag <= frameNoise_q | voteNoisy;
         overrunFlag <= rxFullFlag && !dataRead;
      end else if (dataRead) begin
         rxFullFlag <= 1'b0;
         framingErrFlag <= framingErrFlag && !statusRead;
         noiseFlag <= 1'b0;
         overrunFlag <= 1'b0;
         brkSeenFlag <= 1'b0;
      end
   end
   always_ff @(posedge clock) begin
      if (reset) begin
         rxActiveFlag <= 1'b0;
         rxIrq <= 1'b0;
      end else begin
         rxActiveFlag <= rxState_q != asce_pkg::RX_HUNT;
         rxIrq <= rxFullIrqEnable && rxFullFlag;
      end
   end
   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_pins_released: assert property (@(posedge clock) disable iff (reset)
      !serialUnitEnable |=> !txLineOe && !rxLineOwned)
      else $error("pins not released");
   a_idle_line_one: assert property (@(posedge clock) disable iff (reset)
      txState_q == asce_pkg::TX_IDLE |=> txLine == !$past(txInvert))
      else $error("idle line not at mark");
   a_break_zeros: assert property (@(posedge clock) disable iff (reset)
      txState_q == asce_pkg::TX_BREAK |=> txLine == $past(txInvert))
      else $error("break level wrong");
   a_full_with_fe: assert property (@(posedge clock) disable iff (reset)
      rxDone && !voteLevel |=> rxFullFlag && framingErrFlag)
      else $error("framing error not with full");
   a_break_effects: assert property (@(posedge clock) disable iff (reset)
      rxDone && isBreak |=> brkSeenFlag && serialDataBuffer == 8'h00 && !rxNinthBit)
      else $error("break effects missing");
   a_empty_on_load: assert property (@(posedge clock) disable iff (reset)
      txLoad |=> txBufferEmptyFlag ##1 txState_q == asce_pkg::TX_START)
      else $error("empty not set on transfer");
   a_start_after_pre: assert property (@(posedge clock) disable iff (reset)
      $rose(txState_q == asce_pkg::TX_START) |-> $past(txState_q) != asce_pkg::TX_IDLE)
      else $error("frame without preamble");
   a_break_then_mark: assert property (@(posedge clock) disable iff (reset || !serialUnitEnable)
      txState_q == asce_pkg::TX_BREAK ##1 txState_q != asce_pkg::TX_BREAK |-> txState_q == asce_pkg::TX_MARK)
      else $error("no mark after break");
   a_done_idle: assert property (@(posedge clock) disable iff (reset)
      txDoneFlag |-> txBufferEmptyFlag)
      else $error("done while buffer full");
endmodule // asce_char_engine

// file: verification/asce_remote_dev.sv
// Remote serial device model facing the character engine
`timescale 1ns/10ps
module asce_remote_dev (
   input wire logic clock, // System clock
   input wire logic txLine, // Engine transmit pin
   input wire logic txLineOe, // Engine drives the pin
   input wire logic inv, // Expect inverted levels
   input wire logic nine, // Nine data bits
   output logic rxLine // Engine receive pin
);
   logic [9:0] got[$];
   logic [9:0] fr;
   int i;
   initial rxLine = 1'b1;
   // ---------------------------------------------
   // Frame decoder, mid-bit sampling
   // ---------------------------------------------
   // Start, data LSB first, stop
   always begin
      @(posedge clock);
      if (txLineOe === 1'b1 && (txLine ^ inv) === 1'b0) begin
         fr = 10'h000;
         repeat (8) @(posedge clock);
         for (i = 0; i < (nine ? 9 : 8); i++) begin
            repeat (16) @(posedge clock);
            fr[i] = txLine ^ inv;
         end
         repeat (16) @(posedge clock);
         fr[9] = txLine ^ inv;
         got.push_back(fr);
      end
   end
   // ---------------------------------------------
   // Frame sender
   // ---------------------------------------------
   // Zero stop only when asked; line idles at mark
   task automatic send(input logic [8:0] d, input logic stopv);
      int k;
      @(posedge clock);
      #1 rxLine = 1'b0;
      for (k = 0; k < (nine ? 9 : 8); k++) begin
         repeat (16) @(posedge clock);
         #1 rxLine = d[k];
      end
      repeat (16) @(posedge clock);
      #1 rxLine = stopv;
      repeat (16) @(posedge clock);
      #1 rxLine = 1'b1;
      // Hold mark so the next start follows enough idle samples
      repeat (16) @(posedge clock);
   endtask
endmodule // asce_remote_dev

// file: verification/asce_char_engine_tb.sv
// Self-checking bench for the serial character engine
`timescale 1ns/10ps
module asce_char_engine_tb;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic [7:0] baudDivisor, dataWriteValue, serialDataBuffer, lfsr_q, b;
   logic serialUnitEnable, txEnable, rxEnable, charLengthSelect, txNinthBit, sendBrk, txInvert;
   logic txEmptyIrqEnable, txDoneIrqEnable, rxFullIrqEnable, dataWrite, dataRead, statusRead, rxLine;
   logic txLine, txLineOe, rxLineOwned, rxNinthBit, txBufferEmptyFlag, txDoneFlag, rxFullFlag;
   logic framingErrFlag, brkSeenFlag, noiseFlag, overrunFlag, rxActiveFlag, txIrq, rxIrq;
   logic [9:0] expQ[$];
   int miscompares = 0;
   int tests_run = 0;
   time t0;
   always #20 clock = ~clock;
   asce_char_engine dut (.clock(clock), .reset(reset), .baudDivisor(baudDivisor),
      .serialUnitEnable(serialUnitEnable), .txEnable(txEnable), .rxEnable(rxEnable),
      .charLengthSelect(charLengthSelect), .txNinthBit(txNinthBit), .sendBrk(sendBrk),
      .txInvert(txInvert), .txEmptyIrqEnable(txEmptyIrqEnable), .txDoneIrqEnable(txDoneIrqEnable),
      .rxFullIrqEnable(rxFullIrqEnable), .dataWrite(dataWrite), .dataWriteValue(dataWriteValue),
      .dataRead(dataRead), .statusRead(statusRead), .rxLine(rxLine), .txLine(txLine),
      .txLineOe(txLineOe), .rxLineOwned(rxLineOwned), .serialDataBuffer(serialDataBuffer),
      .rxNinthBit(rxNinthBit), .txBufferEmptyFlag(txBufferEmptyFlag), .txDoneFlag(txDoneFlag),
      .rxFullFlag(rxFullFlag), .framingErrFlag(framingErrFlag), .brkSeenFlag(brkSeenFlag),
      .noiseFlag(noiseFlag), .overrunFlag(overrunFlag), .rxActiveFlag(rxActiveFlag),
      .txIrq(txIrq), .rxIrq(rxIrq));
   asce_remote_dev part (.clock(clock), .txLine(txLine), .txLineOe(txLineOe), .inv(txInvert),
      .nine(charLengthSelect), .rxLine(rxLine));
   // ---------------------------------------------
   // Helpers
   // ---------------------------------------------
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // Bounded so a stuck flag ends as a mismatch, not a hang
   task automatic waitf(input bit done);
      int k;
      k = 0;
      while (((done ? txDoneFlag : txBufferEmptyFlag) !== 1'b1) && k < 5000) begin
         step(1);
         k++;
      end
      if (k == 5000) begin
         miscompares++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      end
   endtask
   task automatic put(input logic [7:0] v);
      waitf(1'b0);
      expQ.push_back({1'b1, charLengthSelect & txNinthBit, v});
      statusRead = 1'b1;
      step(1);
      statusRead = 1'b0;
      dataWrite = 1'b1;
      dataWriteValue = v;
      step(1);
      dataWrite = 1'b0;
      step(1);
   endtask
   task automatic tx_check;
      logic [9:0] e;
      waitf(1'b1);
      step(40);
      while (expQ.size() > 0) begin
         e = expQ.pop_front();
         chk({6'h00, (part.got.size() > 0) ? part.got.pop_front() : 10'h000}, {6'h00, e});
      end
      chk(part.got.size(), 16'h0000);
   endtask
   task automatic rd;
      dataRead = 1'b1;
      step(1);
      dataRead = 1'b0;
      step(1);
   endtask
   task automatic tally_and_finish;
      $display("checks=%0d miscompares=%0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      #(40 * 60000);
      miscompares++;
      tally_and_finish;
   end
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   initial begin
      {serialUnitEnable, txEnable, charLengthSelect, txNinthBit, sendBrk, txInvert} = 6'h00;
      {txEmptyIrqEnable, txDoneIrqEnable, rxFullIrqEnable, dataWrite, dataRead, statusRead} = 6'h00;
      rxEnable = 1'b1;
      baudDivisor = 8'h01;
      dataWriteValue = 8'h00;
      lfsr_q = 8'h0F;
      step(10);
      reset = 1'b0;
      chk({txLine, txLineOe, txBufferEmptyFlag, txDoneFlag, rxFullFlag}, 16'h0016);
      serialUnitEnable = 1'b1;
      txEnable = 1'b1;
      txEmptyIrqEnable = 1'b1;
      rxFullIrqEnable = 1'b1;
      step(2);
      chk(txLine, 16'h0001);
      b = lfsr(lfsr_q);
      fork
         for (int n = 0; n < 3; n++) begin
            lfsr_q = lfsr(lfsr_q);
            put(lfsr_q);
         end
         part.send({1'b0, b}, 1'b1);
      join
      chk({rxFullFlag, rxIrq, framingErrFlag, rxNinthBit, serialDataBuffer}, {3'h6, b[7], b});
      chk({noiseFlag, overrunFlag, rxActiveFlag}, 16'h0000);
      tx_check;
      chk(txIrq, 16'h0001);
      txEmptyIrqEnable = 1'b0;
      txDoneIrqEnable = 1'b1;
      step(2);
      chk(txIrq, 16'h0001);
      txDoneIrqEnable = 1'b0;
      rd;
      chk({rxFullFlag, txIrq}, 16'h0000);
      $display("test eight-bit done");
      charLengthSelect = 1'b1;
      txNinthBit = lfsr_q[0];
      lfsr_q = lfsr(lfsr_q);
      put(lfsr_q);
      tx_check;
      part.send({1'b1, b}, 1'b1);
      chk({rxNinthBit, serialDataBuffer}, {8'h01, b});
      rd;
      charLengthSelect = 1'b0;
      $display("test nine-bit done");
      lfsr_q = lfsr(lfsr_q);
      put(lfsr_q);
      step(200);
      txEnable = 1'b0;
      tx_check;
      txEnable = 1'b1;
      lfsr_q = lfsr(lfsr_q);
      put(lfsr_q);
      waitf(1'b0);
      t0 = $time;
      txEnable = 1'b0;
      step(1);
      txEnable = 1'b1;
      lfsr_q = lfsr(lfsr_q);
      put(lfsr_q);
      waitf(1'b0);
      chk(16'(($time - t0) / 40), 16'(2 * asce_pkg::OVERSAMPLE * (asce_pkg::BITS_SHORT + 2)));
      tx_check;
      b = lfsr(lfsr_q) | 8'h81;
      part.send({1'b0, b}, 1'b0);
      chk({rxFullFlag, framingErrFlag, brkSeenFlag, serialDataBuffer}, {5'h06, b});
      rd;
      part.send(9'h000, 1'b0);
      chk({rxFullFlag, framingErrFlag, brkSeenFlag, rxNinthBit, serialDataBuffer}, 16'h0E00);
      rd;
      $display("test receive errors done");
      sendBrk = 1'b1;
      step(200);
      chk(txLine, 16'h0000);
      sendBrk = 1'b0;
      waitf(1'b1);
      chk(txLine, 16'h0001);
      // Inverting at idle fakes one start for the model; let it drain
      txInvert = 1'b1;
      step(2);
      chk(txLine, 16'h0000);
      step(200);
      part.got.delete();
      lfsr_q = lfsr(lfsr_q);
      put(lfsr_q);
      tx_check;
      serialUnitEnable = 1'b0;
      step(2);
      chk({txLineOe, rxLineOwned}, 16'h0000);
      $display("test break, inversion, release done");
      tally_and_finish;
   end
endmodule // asce_char_engine_tb
